/* design/perf_counter_pkg.sv */
package perf_counter_pkg;
    // ------------------------------------------------------------
    // Register addresses for the model-specific register port
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL_SELECT = 8'h00;
    localparam logic [7:0] ADDR_COUNTER_ZERO = 8'h01;
    localparam logic [7:0] ADDR_COUNTER_ONE = 8'h02;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int EVENT_CODE_W = 6;
    localparam int COUNT_MODE_W = 3;
    localparam int EVENT_CODE_ZERO_LSB = 0;
    localparam int COUNT_MODE_ZERO_LSB = 6;
    localparam int PIN_SELECT_ZERO_BIT = 9;
    localparam int EVENT_CODE_ONE_LSB = 16;
    localparam int COUNT_MODE_ONE_LSB = 22;
    localparam int PIN_SELECT_ONE_BIT = 25;
    localparam int MODE_CLOCKS_BIT = 2;
    localparam int MODE_USER_BIT = 1;
    localparam int MODE_SUPER_BIT = 0;
    localparam logic [31:0] CONTROL_SELECT_RESET = 32'h0000_0000;
    localparam logic [31:0] CONTROL_SELECT_MASK = 32'h03FF_03FF;

    // ------------------------------------------------------------
    // Counter and timing constants
    // ------------------------------------------------------------
    localparam int COUNTER_W = 40;
    localparam logic [39:0] COUNTER_RESET = 40'h00_0000_0000;
    localparam int PIN_LATENCY_CLOCKS = 5;
    localparam logic [1:0] USER_PRIVILEGE = 2'h3;
    localparam logic [1:0] KERNEL_PRIVILEGE = 2'h0;
endpackage : perf_counter_pkg

/* design/dual_event_perf_counters.sv */
// Contract
// - Two independent 40-bit counters, each counting events or clock cycles.
// - Event code zero in control bits 0-5, event code one in bits 16-21.
// - Counting-mode code zero in bits 6-8, mode code one in bits 22-24.
// - Mode top bit selects clocks; middle bit level 3; low bit levels 0-2.
// - Pin-select bit 9/25: 1 shows overflow, 0 shows each increment.
// - Indication pins lag the internal event by a few clocks.
// - Counters may be read while running, without stopping.
// - Reset clears the whole control register, disabling both counters.
// - Increment pin with occurrence events is high each time the event occurs.
// - Increment pin with duration counting stays high while the condition lasts.
// - Counter may advance by 2 per clock; pin only shows an occurrence.
// - Overflow is the carry out of bit 39.
// - Software may preload a counter so it overflows after chosen events.
// - Overflow-mode pin asserts about five clocks after the overflow.
// - In breakpoint signalling the pins carry no counter indication.
// - After reset pins show counter indication until a debugger switches them.
// - Register reads and writes succeed only at privilege level 0.
`timescale 1ns/1ps
`default_nettype none

module dual_event_perf_counters
    import perf_counter_pkg::*;
#(
    parameter int NUM_EVENTS = 64,
    parameter int PIN_LATENCY = PIN_LATENCY_CLOCKS
) (
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic [1:0] CURRENT_PRIVILEGE_LEVEL_I,
    input wire logic [2*NUM_EVENTS-1:0] EVENT_COUNTS_I,
    input wire logic MODEL_REGISTER_READ_I,
    input wire logic MODEL_REGISTER_WRITE_I,
    input wire logic [7:0] MODEL_REGISTER_ADDR_I,
    input wire logic [63:0] MODEL_REGISTER_WDATA_I,
    input wire logic BREAKPOINT_MODE_I,
    input wire logic [1:0] BREAKPOINT_MATCH_I,
    output logic [63:0] MODEL_REGISTER_RDATA_O,
    output logic MODEL_REGISTER_ACK_O,
    output logic MODEL_REGISTER_FAULT_O,
    output logic INDICATION_PIN_ZERO_O,
    output logic INDICATION_PIN_ONE_O
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Event codes are six bits wide, so no further event inputs can be reached
    if (NUM_EVENTS < 1 || NUM_EVENTS > 64) begin : g_bad_events
        $error("NUM_EVENTS must lie in 1..64");
    end
    // The delay line needs at least two stages ahead of the output flop
    if (PIN_LATENCY < 3) begin : g_bad_latency
        $error("PIN_LATENCY must be at least 3");
    end
    // Read data is one 64-bit word and the carry needs a bit above the count
    if (COUNTER_W < 2 || COUNTER_W > 64) begin : g_bad_width
        $error("COUNTER_W must lie in 2..64");
    end

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Privilege filter from a mode code; codes 000 and 100 never count
    function automatic logic mode_allows(input logic [2:0] mode, input logic [1:0] level);
        logic ok;
        ok = (level == USER_PRIVILEGE) ? mode[MODE_USER_BIT] : mode[MODE_SUPER_BIT];
        return ok;
    endfunction : mode_allows

    // A count of three in one clock is legal on the input and is added as given
    // Occurrences of the selected event this clock; unknown codes read as none
    function automatic logic [1:0] event_count(input logic [5:0] code, input logic [2*NUM_EVENTS-1:0] counts);
        logic [1:0] n;
        n = 2'h0;
        if (int'(code) < NUM_EVENTS) begin
            n = counts[2*int'(code) +: 2];
        end
        return n;
    endfunction : event_count

    // Counter chosen by a register offset; only the two counter offsets reach here
    function automatic int counter_index(input logic [7:0] addr);
        int idx;
        idx = (addr == ADDR_COUNTER_ONE) ? 1 : 0;
        return idx;
    endfunction : counter_index

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Registered state; both counters share each per-counter array, indexed 0 and 1
    logic [31:0] control_reg, control_next;
    logic [COUNTER_W-1:0] counter_reg [2];
    logic [COUNTER_W-1:0] counter_next [2];
    logic [PIN_LATENCY-2:0] pipe_reg [2];
    logic [PIN_LATENCY-2:0] pipe_next [2];
    logic [1:0] pin_reg, pin_next;
    logic [63:0] rdata_reg, rdata_next;
    logic ack_reg, ack_next;
    logic fault_reg, fault_next;
    logic [1:0] bkpt_meta_reg, bkpt_sync_reg;
    logic bkpt_mode_meta_reg, bkpt_mode_sync_reg;
    logic [1:0] bkpt_meta_next, bkpt_sync_next;
    logic bkpt_mode_meta_next, bkpt_mode_sync_next;

    // Decoded fields and per-counter arithmetic
    logic [EVENT_CODE_W-1:0] code [2];
    logic [COUNT_MODE_W-1:0] mode [2];
    logic pin_sel [2];
    logic [1:0] step [2];
    logic [COUNTER_W:0] sum [2];
    logic overflow [2];
    logic indicate [2];
    logic access_ok;

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    // One write covers both counters, so per-counter update is read-modify-write in software
    always_comb begin
        code[0] = control_reg[EVENT_CODE_ZERO_LSB +: EVENT_CODE_W];
        code[1] = control_reg[EVENT_CODE_ONE_LSB +: EVENT_CODE_W];
        mode[0] = control_reg[COUNT_MODE_ZERO_LSB +: COUNT_MODE_W];
        mode[1] = control_reg[COUNT_MODE_ONE_LSB +: COUNT_MODE_W];
        pin_sel[0] = control_reg[PIN_SELECT_ZERO_BIT];
        pin_sel[1] = control_reg[PIN_SELECT_ONE_BIT];
    end

    // ------------------------------------------------------------
    // Counting and indication
    // ------------------------------------------------------------
    // Duration mode adds one per clock while the selected condition is present
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            step[i] = 2'h0;
            // Codes 000 and 100 clear both filter bits, so those counters never step
            if (mode_allows(mode[i], CURRENT_PRIVILEGE_LEVEL_I)) begin
                if (mode[i][MODE_CLOCKS_BIT]) begin
                    step[i] = (event_count(code[i], EVENT_COUNTS_I) != 2'h0) ? 2'h1 : 2'h0;
                end else begin
                    step[i] = event_count(code[i], EVENT_COUNTS_I);
                end
            end
            sum[i] = {1'b0, counter_reg[i]} + (COUNTER_W + 1)'(step[i]);
            // A software load in the same clock does not hide the carry: the pin reports the event stream
            overflow[i] = sum[i][COUNTER_W];
            // Pin shows the overflow when pin select is 1, else only that an increment happened, never how many
            indicate[i] = pin_sel[i] ? overflow[i] : (step[i] != 2'h0);
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    // Any access above level 0 faults and leaves every register untouched
    assign access_ok = (CURRENT_PRIVILEGE_LEVEL_I == KERNEL_PRIVILEGE);

    always_comb begin
        control_next = control_reg;
        rdata_next = rdata_reg;
        ack_next = 1'b0;
        fault_next = 1'b0;
        // Overflow wraps past zero, keeping any excess, and the count carries on under the same settings
        for (int i = 0; i < 2; i++) begin
            counter_next[i] = sum[i][COUNTER_W-1:0];
        end
        if (MODEL_REGISTER_READ_I || MODEL_REGISTER_WRITE_I) begin
            ack_next = 1'b1;
            if (!access_ok) begin
                fault_next = 1'b1;
            end else begin
                // An unmapped offset faults just like a privilege miss
                unique case (MODEL_REGISTER_ADDR_I)
                    ADDR_CONTROL_SELECT: begin
                        // Reserved bits are never stored, so a read shows them as zero
                        if (MODEL_REGISTER_WRITE_I) begin
                            control_next = MODEL_REGISTER_WDATA_I[31:0] & CONTROL_SELECT_MASK;
                        end else begin
                            rdata_next = {32'h0, control_reg};
                        end
                    end
                    ADDR_COUNTER_ZERO, ADDR_COUNTER_ONE: begin
                        // Software write wins over a same-clock increment so a preset is exact
                        if (MODEL_REGISTER_WRITE_I) begin
                            counter_next[counter_index(MODEL_REGISTER_ADDR_I)] = MODEL_REGISTER_WDATA_I[COUNTER_W-1:0];
                        end else begin
                            // A running counter is sampled as it stood at the taking edge
                            rdata_next = 64'(counter_reg[counter_index(MODEL_REGISTER_ADDR_I)]);
                        end
                    end
                    default: begin
                        fault_next = 1'b1;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Pin delay line
    // ------------------------------------------------------------
    // Latency models the latch and buffer stages between counter and pad
    // A change of pin select reaches the pad only after the same delay
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pipe_next[i] = {pipe_reg[i][PIN_LATENCY-3:0], indicate[i]};
            // Debugger mode hides counter indication entirely
            // Mode and match are synchronised apart, so a switch may show one stale match clock
            pin_next[i] = bkpt_mode_sync_reg ? bkpt_sync_reg[i] : pipe_reg[i][PIN_LATENCY-2];
        end
    end

    // ------------------------------------------------------------
    // Control and register port registers
    // ------------------------------------------------------------
    // Reset leaves both counters disabled, so nothing counts before software sets them up
    // Answer flags drop after one clock; read data stands until the next good read
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            control_reg <= CONTROL_SELECT_RESET;
            rdata_reg <= 64'h0;
            ack_reg <= 1'b0;
            fault_reg <= 1'b0;
        end else begin
            control_reg <= control_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
            fault_reg <= fault_next;
        end
    end

    // ------------------------------------------------------------
    // Counter registers
    // ------------------------------------------------------------
    // Counters run on every clock; the next value already holds any software load
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            counter_reg[0] <= COUNTER_RESET;
            counter_reg[1] <= COUNTER_RESET;
        end else begin
            counter_reg[0] <= counter_next[0];
            counter_reg[1] <= counter_next[1];
        end
    end

    // ------------------------------------------------------------
    // Indication pin registers
    // ------------------------------------------------------------
    // Pins start low in counter mode, so a monitor sees no false pulse after reset
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            pipe_reg[0] <= '0;
            pipe_reg[1] <= '0;
            pin_reg <= 2'h0;
        end else begin
            pipe_reg[0] <= pipe_next[0];
            pipe_reg[1] <= pipe_next[1];
            pin_reg <= pin_next;
        end
    end

    // ------------------------------------------------------------
    // Debugger input synchronisers
    // ------------------------------------------------------------
    // Both inputs come from the debugger side; only the second stage feeds any logic
    always_comb begin
        bkpt_meta_next = BREAKPOINT_MATCH_I;
        bkpt_sync_next = bkpt_meta_reg;
        bkpt_mode_meta_next = BREAKPOINT_MODE_I;
        bkpt_mode_sync_next = bkpt_mode_meta_reg;
    end

    // A debugger switch therefore lands on the pads three clocks later
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            bkpt_meta_reg <= 2'h0;
            bkpt_sync_reg <= 2'h0;
            bkpt_mode_meta_reg <= 1'b0;
            bkpt_mode_sync_reg <= 1'b0;
        end else begin
            bkpt_meta_reg <= bkpt_meta_next;
            bkpt_sync_reg <= bkpt_sync_next;
            bkpt_mode_meta_reg <= bkpt_mode_meta_next;
            bkpt_mode_sync_reg <= bkpt_mode_sync_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output is a flop, so the pads never see a combinational glitch
    assign MODEL_REGISTER_RDATA_O = rdata_reg;
    assign MODEL_REGISTER_ACK_O = ack_reg;
    assign MODEL_REGISTER_FAULT_O = fault_reg;
    assign INDICATION_PIN_ZERO_O = pin_reg[0];
    assign INDICATION_PIN_ONE_O = pin_reg[1];

endmodule : dual_event_perf_counters

`default_nettype wire

/* test/pin_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// Pin monitor
// ----
module pin_monitor (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic pin_zero_i,
    input wire logic pin_one_i,
    output logic [15:0] high_zero_o,
    output logic [15:0] high_one_o
);
    // Counts high cycles: a pin shows one occurrence per clock, never how many
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            high_zero_o <= 16'h0000;
            high_one_o <= 16'h0000;
        end else begin
            high_zero_o <= high_zero_o + 16'(pin_zero_i);
            high_one_o <= high_one_o + 16'(pin_one_i);
        end
    end
endmodule : pin_monitor
`default_nettype wire

/* test/dual_event_perf_counters_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// Register port and pin checks
// ----
module perf_counter_checker
    import perf_counter_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic [1:0] CURRENT_PRIVILEGE_LEVEL_I,
    input wire logic MODEL_REGISTER_READ_I,
    input wire logic MODEL_REGISTER_WRITE_I,
    input wire logic [7:0] MODEL_REGISTER_ADDR_I,
    input wire logic BREAKPOINT_MODE_I,
    input wire logic [1:0] BREAKPOINT_MATCH_I,
    input wire logic [63:0] MODEL_REGISTER_RDATA_O,
    input wire logic MODEL_REGISTER_ACK_O,
    input wire logic MODEL_REGISTER_FAULT_O,
    input wire logic INDICATION_PIN_ZERO_O,
    input wire logic INDICATION_PIN_ONE_O
);
    // Short aliases; a legal access is kernel level on a mapped address
    wire logic rd = MODEL_REGISTER_READ_I;
    wire logic req = rd | MODEL_REGISTER_WRITE_I;
    wire logic ack = MODEL_REGISTER_ACK_O;
    wire logic flt = MODEL_REGISTER_FAULT_O;
    wire logic [7:0] adr = MODEL_REGISTER_ADDR_I;
    wire logic [63:0] rdat = MODEL_REGISTER_RDATA_O;
    wire logic legal = CURRENT_PRIVILEGE_LEVEL_I == KERNEL_PRIVILEGE && adr <= ADDR_COUNTER_ONE;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    sequence good_read; rd && legal; endsequence
    sequence pins_parked; (BREAKPOINT_MODE_I && BREAKPOINT_MATCH_I == 2'h0) [*6]; endsequence
    chk_ack_follows: assert property (req |=> ack) else $error("no ack");
    chk_ack_quiet: assert property (!req |=> !ack) else $error("ack without request");
    chk_fault_priv: assert property (req && !legal |=> flt) else $error("bad access not refused");
    chk_legal_ok: assert property (req && legal |=> !flt) else $error("legal access refused");
    chk_fault_ack: assert property (flt |-> ack) else $error("fault without ack");
    chk_rdata_holds: assert property (!(rd && legal) |=> $stable(rdat)) else $error("read data moved");
    chk_ctl_masked: assert property (good_read ##0 adr == ADDR_CONTROL_SELECT |=>
        (rdat & ~{32'h0, CONTROL_SELECT_MASK}) == 64'h0) else $error("reserved bits set");
    chk_bp_quiet: assert property (pins_parked |-> !INDICATION_PIN_ZERO_O && !INDICATION_PIN_ONE_O)
        else $error("pin shows counter in breakpoint mode");
endmodule : perf_counter_checker

bind dual_event_perf_counters perf_counter_checker chk (.CLK_I, .RESETN_I, .CURRENT_PRIVILEGE_LEVEL_I,
    .MODEL_REGISTER_READ_I, .MODEL_REGISTER_WRITE_I, .MODEL_REGISTER_ADDR_I, .BREAKPOINT_MODE_I,
    .BREAKPOINT_MATCH_I, .MODEL_REGISTER_RDATA_O, .MODEL_REGISTER_ACK_O, .MODEL_REGISTER_FAULT_O,
    .INDICATION_PIN_ZERO_O, .INDICATION_PIN_ONE_O);
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; $display("BAD %0t %h %h", $time, a, b); end end
module tb;
    import perf_counter_pkg::*;
    typedef struct {logic [31:0] ctl; logic [1:0] prv; logic [39:0] e0; logic [39:0] e1;} row_t;
    localparam logic [127:0] EVP = 128'h18; // Event one twice, event two once per clock
    logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, bpm = 1'b0, ack, flt, p0, p1;
    logic [1:0] prv = 2'h0, bpx = 2'h0;
    logic [7:0] ad = 8'h00;
    logic [63:0] wd = 64'h0, rdat;
    logic [127:0] ev = 128'h0;
    logic [15:0] h0, h1, s0, s1;
    int fail_count = 0;
    int comparisons = 0;
    // Every mode code, privilege on both sides of the filter, two counted clocks each
    row_t rows [8] = '{'{32'h00C2_00C1, 2'h0, 40'h4, 40'h2}, '{32'h0002_0001, 2'h0, 40'h0, 40'h0},
        '{32'h0102_0101, 2'h0, 40'h0, 40'h0}, '{32'h0082_0041, 2'h0, 40'h4, 40'h0},
        '{32'h0082_0041, 2'h3, 40'h0, 40'h2}, '{32'h0182_0141, 2'h3, 40'h0, 40'h2},
        '{32'h01C2_01C1, 2'h1, 40'h2, 40'h2}, '{32'h0142_0181, 2'h2, 40'h0, 40'h2}};
    always #10 clk = ~clk;
    dual_event_perf_counters DUT (.CLK_I(clk), .RESETN_I(rstn), .CURRENT_PRIVILEGE_LEVEL_I(prv),
        .EVENT_COUNTS_I(ev), .MODEL_REGISTER_READ_I(rd), .MODEL_REGISTER_WRITE_I(wr), .MODEL_REGISTER_ADDR_I(ad),
        .MODEL_REGISTER_WDATA_I(wd), .BREAKPOINT_MODE_I(bpm), .BREAKPOINT_MATCH_I(bpx),
        .MODEL_REGISTER_RDATA_O(rdat), .MODEL_REGISTER_ACK_O(ack), .MODEL_REGISTER_FAULT_O(flt),
        .INDICATION_PIN_ZERO_O(p0), .INDICATION_PIN_ONE_O(p1));
    pin_monitor mon (.clk_i(clk), .rst_n_i(rstn), .pin_zero_i(p0), .pin_one_i(p1), .high_zero_o(h0),
        .high_one_o(h1));
    task stop_test;
        if (fail_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    // One access; the answer stands only in the cycle after the taking edge
    task acc(input logic w, input logic [7:0] a, input logic [63:0] d, input logic f);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        ad <= a;
        wd <= d;
        @(posedge clk);
        rd <= 1'b0;
        wr <= 1'b0;
        #1;
        `CHK({ack, flt}, {1'b1, f})
    endtask : acc
    task rdchk(input logic [7:0] a, input logic [63:0] e);
        acc(1'b0, a, 64'h0, 1'b0);
        `CHK(rdat, e)
    endtask : rdchk
    // Stop, clear, set up, then two clocks of events under the row's privilege
    task run(input row_t r);
        acc(1'b1, ADDR_CONTROL_SELECT, 64'h0, 1'b0);
        acc(1'b1, ADDR_COUNTER_ZERO, 64'h0, 1'b0);
        acc(1'b1, ADDR_COUNTER_ONE, 64'h0, 1'b0);
        acc(1'b1, ADDR_CONTROL_SELECT, {32'h0, r.ctl}, 1'b0);
        rdchk(ADDR_CONTROL_SELECT, {32'h0, r.ctl});
        @(posedge clk);
        prv <= r.prv;
        ev <= EVP;
        repeat (2) @(posedge clk);
        prv <= 2'h0;
        ev <= 128'h0;
        rdchk(ADDR_COUNTER_ZERO, {24'h0, r.e0});
        rdchk(ADDR_COUNTER_ONE, {24'h0, r.e1});
    endtask : run
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rdchk(ADDR_CONTROL_SELECT, 64'h0);
        acc(1'b1, ADDR_CONTROL_SELECT, '1, 1'b0);
        rdchk(ADDR_CONTROL_SELECT, {32'h0, CONTROL_SELECT_MASK});
        @(posedge clk);
        prv <= 2'h3;
        acc(1'b0, ADDR_COUNTER_ZERO, 64'h0, 1'b1);
        @(posedge clk);
        prv <= 2'h0;
        acc(1'b0, 8'h03, 64'h0, 1'b1);
        `CHK(rdat, {32'h0, CONTROL_SELECT_MASK})
        foreach (rows[i]) run(rows[i]);
        // Pins lag the counted clock; three clocks give three high cycles
        acc(1'b1, ADDR_CONTROL_SELECT, 64'h01C2_00C1, 1'b0);
        s0 = h0;
        s1 = h1;
        @(posedge clk);
        ev <= EVP;
        for (int i = 1; i <= 8; i++) begin
            @(posedge clk);
            if (i == 3) ev <= 128'h0;
            #1;
            `CHK(p0, i >= 5 && i <= 7)
            `CHK(p1, i >= 5 && i <= 7)
        end
        `CHK(h0, s0 + 16'h3)
        `CHK(h1, s1 + 16'h3)
        // Preset near the top, read while counting, one overflow pulse
        acc(1'b1, ADDR_CONTROL_SELECT, 64'h0000_02C1, 1'b0);
        acc(1'b1, ADDR_COUNTER_ZERO, 64'hFF_FFFF_FFFD, 1'b0);
        s0 = h0;
        @(posedge clk);
        ev <= EVP;
        acc(1'b0, ADDR_COUNTER_ZERO, 64'h0, 1'b0);
        `CHK(rdat, 64'hFF_FFFF_FFFF)
        @(posedge clk);
        ev <= 128'h0;
        // One pulse, five clocks after the clock that carried out of the top bit
        for (int i = 4; i <= 11; i++) begin
            @(posedge clk);
            #1;
            `CHK(p0, i == 6)
        end
        `CHK(h0, s0 + 16'h1)
        rdchk(ADDR_COUNTER_ZERO, 64'h3);
        @(posedge clk);
        bpm <= 1'b1;
        bpx <= 2'h2;
        repeat (6) @(posedge clk);
        #1;
        `CHK({p1, p0}, 2'h2)
        @(posedge clk);
        bpx <= 2'h0;
        repeat (8) @(posedge clk);
        bpm <= 1'b0;
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rdchk(ADDR_CONTROL_SELECT, 64'h0);
        stop_test();
    end
endmodule : tb
`default_nettype wire
